// ### hw/timer_block_params.svh
// constants for the split timer and capture/reload timer block
// Function
// - timer one in its split mode holds count
// - split mode makes two independent 8-bit counters
// - low byte counts clock or zero-pin falls
// - high byte counts clock, uses one's run/flag
// - timer one runs without run bit or flag while timer 0 is split
// - third timer clocked by pin or prescale, run-gated
// - capture mode counts up, rollover sets flag
// - trigger fall captures count and sets trigger flag
// - clear-after-capture zeroes count after each capture
// - up reload mode reloads from capture pair
// - trigger fall forces reload in up mode
// - up/down follows trigger pin level, reloads up
// - down count past capture value loads FFFF
// - up/down reload sets flag, toggles trigger flag
// - baud mode reloads without setting overflow flag
// - baud mode trigger fall sets trigger flag
// - clock-out outside up/down gives 50% clock, no overflow interrupt
// - clock-out rate is clock over four times count
// - prescale 12 after reset, 4 when time-base set
`ifndef TIMER_BLOCK_PARAMS_SVH
`define TIMER_BLOCK_PARAMS_SVH

// register offsets on the plain register port
`define OFS_TIMER_MODE 4'h0
`define OFS_TIMER_CTRL 4'h1
`define OFS_T0_LOW 4'h2
`define OFS_T0_HIGH 4'h3
`define OFS_T1_LOW 4'h4
`define OFS_T1_HIGH 4'h5
`define OFS_CLOCK_CTRL 4'h6
`define OFS_T2_CTRL 4'h7
`define OFS_T2_MODE 4'h8
`define OFS_CAP_LOW 4'h9
`define OFS_CAP_HIGH 4'hA
`define OFS_T2_LOW 4'hB
`define OFS_T2_HIGH 4'hC

// timer mode register fields
`define TM_T0_MODE_LSB 0
`define TM_T0_FUNC 2
`define TM_T0_GATE 3
`define TM_T1_MODE_LSB 4
`define TM_T1_FUNC 6
`define TM_T1_GATE 7
// timer control register fields
`define TC_T0_RUN 4
`define TC_T0_FLAG 5
`define TC_T1_RUN 6
`define TC_T1_FLAG 7
// clock control register fields
`define CK_T0_BASE 3
`define CK_T1_BASE 4
`define CK_T2_BASE 5
// third timer control register fields
`define T2C_SELECT 0
`define T2C_FUNC 1
`define T2C_RUN 2
`define T2C_TRIG_EN 3
`define T2C_TX_CLK 4
`define T2C_RX_CLK 5
`define T2C_TRIG_FLAG 6
`define T2C_OVF_FLAG 7
// third timer mode register fields
`define T2M_UPDOWN 0
`define T2M_CLKOUT 1
`define T2M_CLEAR 3

// reset values and the all-ones count top
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define COUNT_TOP 16'hFFFF
// prescale divisors minus one, and the split mode code
`define PRE_LAST_12 4'hB
`define PRE_LAST_4 2'h3
`define SPLIT_MODE 2'h3

`endif

// ### hw/timer_block_pkg.sv
// types shared by the split timer and capture/reload timer block
package timer_block_pkg;

   // external pins, all asynchronous to core_clk
   typedef struct packed {
      logic extIrqPinZero;
      logic extIrqPinOne;
      logic timerZeroCountPin;
      logic timerOneCountPin;
      logic thirdTimerCountPin;
      logic thirdTimerTriggerPin;
   } pins_t;

   // register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // whole block state
   typedef struct packed {
      logic [7:0] timerModeReg;
      logic [7:0] timerCtrlReg;
      logic [7:0] timerZeroLowByte;
      logic [7:0] timerZeroHighByte;
      logic [7:0] timerOneLow;
      logic [7:0] timerOneHigh;
      logic [7:0] clockControlReg;
      logic [7:0] thirdTimerControlReg;
      logic [7:0] thirdTimerModeReg;
      logic [15:0] capture;
      logic [15:0] thirdTimerCount;
      logic [3:0] pre;
      pins_t sync1;
      pins_t sync2;
      pins_t prev;
      logic clockOut;
      logic [7:0] rdata;
      logic irqZero;
      logic irqOne;
      logic irqTwo;
   } state_t;

endpackage

// ### hw/timer_block.sv
// split timer 0/1 and capture/reload timer 2 with register port
`timescale 1ns/1ns
`default_nettype none
`include "timer_block_params.svh"

module timer_block (
   input wire logic core_clk, // 125 MHz clock
   input wire logic resetn, // synchronous reset, active low
   input wire timer_block_pkg::reg_req_t regReq, // register access
   output logic [7:0] regRdata, // read data, cycle after read strobe
   input wire timer_block_pkg::pins_t pinsIn, // asynchronous pin levels
   output logic thirdTimerPinOut, // clock-out drive level
   output logic thirdTimerPinOe, // clock-out drive enable
   output logic irqTimerZero, // timer 0 overflow request
   output logic irqTimerOne, // timer 1 overflow request
   output logic irqThirdTimer // timer 2 request
);

   timer_block_pkg::state_t st_r;
   timer_block_pkg::state_t st_nxt;

   // one step of a classic timer in modes 0-2; returns {ovf, high, low}
   // mode 3 leaves the count alone: callers handle split and freeze
   function automatic logic [16:0] stepClassic(input logic [7:0] hi, input logic [7:0] lo, input logic [1:0] mode);
      logic [16:0] res;
      res = {1'b0, hi, lo};
      case (mode)
         2'h0: begin
            res[4:0] = lo[4:0] + 5'h01;
            if (lo[4:0] == 5'h1F) begin
               res[15:8] = hi + 8'h01;
               res[16] = (hi == 8'hFF);
            end
         end
         2'h1: begin
            res[15:0] = {hi, lo} + 16'h0001;
            res[16] = ({hi, lo} == `COUNT_TOP);
         end
         2'h2: begin
            res[7:0] = (lo == 8'hFF) ? hi : lo + 8'h01;
            res[16] = (lo == 8'hFF);
         end
         default: begin
            res = {1'b0, hi, lo};
         end
      endcase
      return res;
   endfunction

   // combinational next state
   always_comb begin
      logic tick4;
      logic tick12;
      logic tick2;
      logic rate0;
      logic rate1;
      logic rate2;
      logic [5:0] falls;
      logic fallZero;
      logic fallOne;
      logic fallTwo;
      logic fallTrig;
      logic [1:0] m0;
      logic [1:0] m1;
      logic split0;
      logic step0;
      logic step1;
      logic stepHigh;
      logic [16:0] r0;
      logic [16:0] r1;
      logic ovf0;
      logic ovf1;
      logic ovf2;
      logic trig2;
      logic trigFall;
      logic tick2t;
      logic baud;
      logic clkOutMode;
      logic upDownMode;
      logic toggleOut;
      logic [15:0] cnt;
      logic [7:0] wd;
      st_nxt = st_r;
      ovf0 = 1'b0;
      ovf1 = 1'b0;
      ovf2 = 1'b0;
      trig2 = 1'b0;
      toggleOut = 1'b0;
      wd = regReq.wdata;
      // defaults so no working signal can hold a value as a latch
      tick4 = 1'b0;
      tick12 = 1'b0;
      tick2 = 1'b0;
      rate0 = 1'b0;
      rate1 = 1'b0;
      rate2 = 1'b0;
      falls = 6'h00;
      fallZero = 1'b0;
      fallOne = 1'b0;
      fallTwo = 1'b0;
      fallTrig = 1'b0;
      m0 = 2'h0;
      m1 = 2'h0;
      split0 = 1'b0;
      step0 = 1'b0;
      step1 = 1'b0;
      stepHigh = 1'b0;
      r0 = 17'h00000;
      r1 = 17'h00000;
      trigFall = 1'b0;
      tick2t = 1'b0;
      baud = 1'b0;
      clkOutMode = 1'b0;
      upDownMode = 1'b0;
      cnt = 16'h0000;

      // pin synchronisers and falling edge detect on settled samples
      // only the second flop and its delayed copy feed logic; the first may be metastable
      st_nxt.sync1 = pinsIn;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.prev = st_r.sync2;
      falls = st_r.prev & ~st_r.sync2;
      // named edges keep the carrier's bit order out of the logic below
      fallZero = falls[3];
      fallOne = falls[2];
      fallTwo = falls[1];
      fallTrig = falls[0];

      // shared prescaler: 12-cycle machine rate or 4-cycle turbo rate
      // one counter keeps the /12, /4 and /2 ticks in step
      st_nxt.pre = (st_r.pre == `PRE_LAST_12) ? 4'h0 : st_r.pre + 4'h1;
      tick12 = (st_r.pre == `PRE_LAST_12);
      tick4 = (st_r.pre[1:0] == `PRE_LAST_4);
      tick2 = st_r.pre[0];
      rate0 = st_r.clockControlReg[`CK_T0_BASE] ? tick4 : tick12;
      rate1 = st_r.clockControlReg[`CK_T1_BASE] ? tick4 : tick12;
      rate2 = st_r.clockControlReg[`CK_T2_BASE] ? tick4 : tick12;

      // timer 0: gated run, clock or pin source
      m0 = st_r.timerModeReg[`TM_T0_MODE_LSB +: 2];
      m1 = st_r.timerModeReg[`TM_T1_MODE_LSB +: 2];
      split0 = (m0 == `SPLIT_MODE);
      // run bit, gate level and source must all agree
      step0 = st_r.timerCtrlReg[`TC_T0_RUN]
         && (!st_r.timerModeReg[`TM_T0_GATE] || st_r.sync2.extIrqPinZero)
         && (st_r.timerModeReg[`TM_T0_FUNC] ? fallZero : rate0);
      if (split0) begin
         // low byte stands alone with timer 0's controls and flag
         if (step0) begin
            st_nxt.timerZeroLowByte = st_r.timerZeroLowByte + 8'h01;
            ovf0 = (st_r.timerZeroLowByte == 8'hFF);
         end
         // high byte always counts prescaled clock, borrows timer 1's run and flag
         stepHigh = st_r.timerCtrlReg[`TC_T1_RUN] && rate0;
         if (stepHigh) begin
            st_nxt.timerZeroHighByte = st_r.timerZeroHighByte + 8'h01;
            ovf1 = (st_r.timerZeroHighByte == 8'hFF);
         end
      end else if (step0) begin
         r0 = stepClassic(st_r.timerZeroHighByte, st_r.timerZeroLowByte, m0);
         st_nxt.timerZeroHighByte = r0[15:8];
         st_nxt.timerZeroLowByte = r0[7:0];
         ovf0 = r0[16];
      end

      // timer 1: own split mode freezes it; with timer 0 split it loses run bit and flag
      step1 = (m1 != `SPLIT_MODE)
         && (split0 || st_r.timerCtrlReg[`TC_T1_RUN])
         && (!st_r.timerModeReg[`TM_T1_GATE] || st_r.sync2.extIrqPinOne)
         && (st_r.timerModeReg[`TM_T1_FUNC] ? fallOne : rate1);
      if (step1) begin
         r1 = stepClassic(st_r.timerOneHigh, st_r.timerOneLow, m1);
         st_nxt.timerOneHigh = r1[15:8];
         st_nxt.timerOneLow = r1[7:0];
         // the split high byte owns flag one, so timer 1 stays silent
         if (!split0) begin
            ovf1 = r1[16];
         end
      end

      // timer 2 mode decode
      // baud outranks capture and up/down; up/down is ignored in baud
      baud = st_r.thirdTimerControlReg[`T2C_RX_CLK] || st_r.thirdTimerControlReg[`T2C_TX_CLK];
      clkOutMode = st_r.thirdTimerModeReg[`T2M_CLKOUT] && !st_r.thirdTimerControlReg[`T2C_FUNC]
         && !st_r.thirdTimerControlReg[`T2C_SELECT];
      upDownMode = !st_r.thirdTimerControlReg[`T2C_SELECT] && st_r.thirdTimerModeReg[`T2M_UPDOWN] && !baud;
      // baud and clock-out run from clock/2 (baud counts pin falls when T2C_FUNC is set), so the output period is four clocks per count
      tick2t = st_r.thirdTimerControlReg[`T2C_RUN] && (st_r.thirdTimerControlReg[`T2C_FUNC] ? fallTwo
         : ((baud || clkOutMode) ? tick2 : rate2));
      trigFall = st_r.thirdTimerControlReg[`T2C_TRIG_EN] && fallTrig;
      cnt = st_r.thirdTimerCount;

      if (baud || (clkOutMode && !upDownMode)) begin
         // auto-reload with no overflow flag
         if (tick2t) begin
            if (cnt == `COUNT_TOP) begin
               st_nxt.thirdTimerCount = st_r.capture;
               toggleOut = 1'b1;
            end else begin
               st_nxt.thirdTimerCount = cnt + 16'h0001;
            end
         end
         trig2 = baud && trigFall;
      end else if (st_r.thirdTimerControlReg[`T2C_SELECT]) begin
         // capture mode
         // clear-after-capture beats a same-cycle increment
         if (tick2t) begin
            st_nxt.thirdTimerCount = cnt + 16'h0001;
            ovf2 = (cnt == `COUNT_TOP);
         end
         if (trigFall) begin
            st_nxt.capture = cnt;
            trig2 = 1'b1;
            if (st_r.thirdTimerModeReg[`T2M_CLEAR]) begin
               st_nxt.thirdTimerCount = `RST_WORD;
            end
         end
      end else if (!upDownMode) begin
         // up-only auto-reload
         if (tick2t) begin
            if (cnt == `COUNT_TOP) begin
               st_nxt.thirdTimerCount = st_r.capture;
               ovf2 = 1'b1;
            end else begin
               st_nxt.thirdTimerCount = cnt + 16'h0001;
            end
         end
         if (trigFall) begin
            st_nxt.thirdTimerCount = st_r.capture;
            trig2 = 1'b1;
         end
      end else if (tick2t) begin
         // up/down auto-reload, direction from trigger pin level
         // a down count from the reload value wraps to all ones
         if (st_r.sync2.thirdTimerTriggerPin) begin
            if (cnt == `COUNT_TOP) begin
               st_nxt.thirdTimerCount = st_r.capture;
               ovf2 = 1'b1;
            end else begin
               st_nxt.thirdTimerCount = cnt + 16'h0001;
            end
         end else if (cnt == st_r.capture) begin
            st_nxt.thirdTimerCount = `COUNT_TOP;
            ovf2 = 1'b1;
         end else begin
            st_nxt.thirdTimerCount = cnt - 16'h0001;
         end
      end

      // clock-out toggles on each reload so duty is exactly half
      // dropping the run bit parks the pin low
      if (clkOutMode && st_r.thirdTimerControlReg[`T2C_RUN]) begin
         if (toggleOut) begin
            st_nxt.clockOut = ~st_r.clockOut;
         end
      end else begin
         st_nxt.clockOut = 1'b0;
      end

      // software writes; counts take the written value over a same-cycle step
      // the step lost to such a write is not made up later
      if (regReq.wr) begin
         if (regReq.addr == `OFS_TIMER_MODE) begin
            st_nxt.timerModeReg = wd;
         end else if (regReq.addr == `OFS_TIMER_CTRL) begin
            st_nxt.timerCtrlReg = wd;
         end else if (regReq.addr == `OFS_T0_LOW) begin
            st_nxt.timerZeroLowByte = wd;
         end else if (regReq.addr == `OFS_T0_HIGH) begin
            st_nxt.timerZeroHighByte = wd;
         end else if (regReq.addr == `OFS_T1_LOW) begin
            st_nxt.timerOneLow = wd;
         end else if (regReq.addr == `OFS_T1_HIGH) begin
            st_nxt.timerOneHigh = wd;
         end else if (regReq.addr == `OFS_CLOCK_CTRL) begin
            st_nxt.clockControlReg = wd;
         end else if (regReq.addr == `OFS_T2_CTRL) begin
            st_nxt.thirdTimerControlReg = wd;
         end else if (regReq.addr == `OFS_T2_MODE) begin
            st_nxt.thirdTimerModeReg = wd;
         end else if (regReq.addr == `OFS_CAP_LOW) begin
            st_nxt.capture[7:0] = wd;
         end else if (regReq.addr == `OFS_CAP_HIGH) begin
            st_nxt.capture[15:8] = wd;
         end else if (regReq.addr == `OFS_T2_LOW) begin
            st_nxt.thirdTimerCount[7:0] = wd;
         end else if (regReq.addr == `OFS_T2_HIGH) begin
            st_nxt.thirdTimerCount[15:8] = wd;
         end
      end

      // hardware flag sets win over a same-cycle software clear
      // in up/down the trigger flag toggles on reload instead of setting
      if (ovf0) begin
         st_nxt.timerCtrlReg[`TC_T0_FLAG] = 1'b1;
      end
      if (ovf1) begin
         st_nxt.timerCtrlReg[`TC_T1_FLAG] = 1'b1;
      end
      if (ovf2) begin
         st_nxt.thirdTimerControlReg[`T2C_OVF_FLAG] = 1'b1;
      end
      if (upDownMode) begin
         if (ovf2) begin
            st_nxt.thirdTimerControlReg[`T2C_TRIG_FLAG] = ~st_r.thirdTimerControlReg[`T2C_TRIG_FLAG];
         end
      end else if (trig2) begin
         st_nxt.thirdTimerControlReg[`T2C_TRIG_FLAG] = 1'b1;
      end

      // read data, valid in the cycle after the strobe only; unmapped reads zero
      // counts are not latched: read low then high and watch for a carry
      st_nxt.rdata = `RST_BYTE;
      if (regReq.rd) begin
         if (regReq.addr == `OFS_TIMER_MODE) begin
            st_nxt.rdata = st_r.timerModeReg;
         end else if (regReq.addr == `OFS_TIMER_CTRL) begin
            st_nxt.rdata = st_r.timerCtrlReg;
         end else if (regReq.addr == `OFS_T0_LOW) begin
            st_nxt.rdata = st_r.timerZeroLowByte;
         end else if (regReq.addr == `OFS_T0_HIGH) begin
            st_nxt.rdata = st_r.timerZeroHighByte;
         end else if (regReq.addr == `OFS_T1_LOW) begin
            st_nxt.rdata = st_r.timerOneLow;
         end else if (regReq.addr == `OFS_T1_HIGH) begin
            st_nxt.rdata = st_r.timerOneHigh;
         end else if (regReq.addr == `OFS_CLOCK_CTRL) begin
            st_nxt.rdata = st_r.clockControlReg;
         end else if (regReq.addr == `OFS_T2_CTRL) begin
            st_nxt.rdata = st_r.thirdTimerControlReg;
         end else if (regReq.addr == `OFS_T2_MODE) begin
            st_nxt.rdata = st_r.thirdTimerModeReg;
         end else if (regReq.addr == `OFS_CAP_LOW) begin
            st_nxt.rdata = st_r.capture[7:0];
         end else if (regReq.addr == `OFS_CAP_HIGH) begin
            st_nxt.rdata = st_r.capture[15:8];
         end else if (regReq.addr == `OFS_T2_LOW) begin
            st_nxt.rdata = st_r.thirdTimerCount[7:0];
         end else if (regReq.addr == `OFS_T2_HIGH) begin
            st_nxt.rdata = st_r.thirdTimerCount[15:8];
         end
      end

      // interrupt requests follow the flags; trigger flag is silent in up/down
      st_nxt.irqZero = st_nxt.timerCtrlReg[`TC_T0_FLAG];
      st_nxt.irqOne = st_nxt.timerCtrlReg[`TC_T1_FLAG];
      st_nxt.irqTwo = st_nxt.thirdTimerControlReg[`T2C_OVF_FLAG]
         || (st_nxt.thirdTimerControlReg[`T2C_TRIG_FLAG] && !upDownMode);
   end

   // state register; reset gives the 1/12 time base
   // whole state word clears on one edge; no asynchronous path
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from flops
   // the enable follows its bit alone, so the pin drives even when stopped
   assign regRdata = st_r.rdata;
   assign thirdTimerPinOut = st_r.clockOut;
   assign thirdTimerPinOe = st_r.thirdTimerModeReg[`T2M_CLKOUT];
   assign irqTimerZero = st_r.irqZero;
   assign irqTimerOne = st_r.irqOne;
   assign irqThirdTimer = st_r.irqTwo;

endmodule
`default_nettype wire

// ### dv/timer_block_assertions.sv
// port-level checker for the timer block
`timescale 1ns/1ns
`default_nettype none
`include "timer_block_params.svh"

module timer_block_assertions (
   input wire logic core_clk, // clock
   input wire logic resetn, // reset, active low
   input wire timer_block_pkg::reg_req_t regReq, // register access
   input wire logic [7:0] regRdata, // read data
   input wire logic thirdTimerPinOe, // clock-out enable
   input wire logic irqTimerZero, // timer 0 request
   input wire logic irqTimerOne, // timer 1 request
   input wire logic irqThirdTimer // timer 2 request
);
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   // a capture-high write followed two cycles later by its read back
   sequence capWrite;
      regReq.wr && regReq.addr == `OFS_CAP_HIGH;
   endsequence
   sequence capRead;
      regReq.rd && regReq.addr == `OFS_CAP_HIGH;
   endsequence

   a_read_idle: assert property (!$past(regReq.rd) |-> regRdata == 8'h00)
      else $error("read data not zero outside an answer");
   a_unmapped_zero: assert property (regReq.rd && regReq.addr > `OFS_T2_HIGH |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   a_cap_readback: assert property (capWrite ##2 capRead |=> regRdata == $past(regReq.wdata, 3))
      else $error("capture pair read back wrong");
   // both latencies of the enable flop are settled two cycles on
   a_oe_follow: assert property (regReq.wr && regReq.addr == `OFS_T2_MODE |-> ##2
      thirdTimerPinOe == $past(regReq.wdata[`T2M_CLKOUT], 2))
      else $error("clock-out enable does not follow its bit");
   a_flag_zero: assert property (regReq.wr && regReq.addr == `OFS_TIMER_CTRL
      && regReq.wdata[`TC_T0_FLAG] |=> irqTimerZero)
      else $error("timer 0 request not raised by its flag");
   a_flag_one: assert property (regReq.wr && regReq.addr == `OFS_TIMER_CTRL
      && regReq.wdata[`TC_T1_FLAG] |=> irqTimerOne)
      else $error("timer 1 request not raised by its flag");
   // only software clears a flag, save the up/down trigger flag toggle, so a request holds between control writes
   a_irq_hold: assert property (irqTimerZero && !(regReq.wr && regReq.addr == `OFS_TIMER_CTRL)
      |=> irqTimerZero)
      else $error("timer 0 request dropped on its own");
   a_third_hold: assert property (irqThirdTimer && !(regReq.wr && (regReq.addr == `OFS_T2_CTRL
      || regReq.addr == `OFS_T2_MODE)) |=> irqThirdTimer)
      else $error("timer 2 request dropped on its own");
endmodule

bind timer_block timer_block_assertions i_chk (.core_clk, .resetn, .regReq, .regRdata,
   .thirdTimerPinOe, .irqTimerZero, .irqTimerOne, .irqThirdTimer);

`default_nettype wire

// ### dv/pin_model.sv
// pin-side model: count, trigger and interrupt pins
`timescale 1ns/1ns
`default_nettype none

module pin_model (
   input wire logic core_clk, // clock
   output timer_block_pkg::pins_t pins // pin levels
);
   // interrupt pins idle high so gated timers stay open
   initial pins = '1;

   // 4 cycles low then 4 high, well above the 1-cycle minimum of the synchroniser
   task automatic fall(input int idx);
      @(posedge core_clk) pins[idx] <= 1'b0;
      repeat (4) @(posedge core_clk);
      pins[idx] <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask

   // a level change, given time to pass the two sync flops
   task automatic level(input int idx, input logic v);
      @(posedge core_clk) pins[idx] <= v;
      repeat (4) @(posedge core_clk);
   endtask
endmodule

`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the timer block
`timescale 1ns/1ns
`default_nettype none
`include "timer_block_params.svh"

module tb_top;
   typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   timer_block_pkg::reg_req_t regReq = '0;
   timer_block_pkg::pins_t pinsIn;
   logic [7:0] regRdata;
   logic pinOut, pinOe, irq0, irq1, irq2, lastOut;
   int error_cnt = 0;
   int num_checks = 0;
   int toggles;
   row_t rows [7] = '{'{`OFS_TIMER_MODE, 8'h5A, 8'h5A}, '{`OFS_T1_LOW, 8'h77, 8'h77},
      '{`OFS_CAP_HIGH, 8'h12, 8'h12}, '{`OFS_T2_MODE, 8'h0B, 8'h0B}, '{`OFS_TIMER_CTRL, 8'hA0, 8'hA0},
      '{`OFS_T2_CTRL, 8'h80, 8'h80}, '{4'hF, 8'h55, 8'h00}};

   always #4 core_clk = ~core_clk;

   pin_model i_pins (.core_clk(core_clk), .pins(pinsIn));
   timer_block i_dut (.core_clk(core_clk), .resetn(resetn), .regReq(regReq), .regRdata(regRdata),
      .pinsIn(pinsIn), .thirdTimerPinOut(pinOut), .thirdTimerPinOe(pinOe), .irqTimerZero(irq0),
      .irqTimerOne(irq1), .irqThirdTimer(irq2));

   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask

   // one-cycle strobes; the idle cycle after each keeps drivers from double assignment
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk) regReq <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk) regReq <= '0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
      @(posedge core_clk) regReq <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge core_clk) regReq <= '0;
      #1 chk(n, regRdata, e);
   endtask

   task automatic complete_run;
      if (error_cnt == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      complete_run;
   end

   initial begin
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      // plain register places, an unmapped one among them
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e, "row");
      end
      // second reset in mid-run clears every place, the clock-out enable and the three requests
      @(posedge core_clk) resetn <= 1'b0;
      @(posedge core_clk) resetn <= 1'b1;
      for (int a = 0; a <= 12; a++) rd(4'(a), 8'h00, "reset");
      chk("reset out", {pinOe, irq0, irq1, irq2}, 16'h0000);
      // 240 run edges hold a whole number of prescale periods, so the tick count is exact
      for (int b = 0; b < 2; b++) begin
         wr(`OFS_CLOCK_CTRL, b ? 8'h20 : 8'h00);
         wr(`OFS_T2_LOW, 8'h00);
         wr(`OFS_T2_CTRL, 8'h05);
         repeat (238) @(posedge core_clk);
         wr(`OFS_T2_CTRL, 8'h01);
         rd(`OFS_T2_LOW, b ? 8'h3C : 8'h14, "prescale");
      end
      // split timer 0: low byte on pin falls only, high byte on clock under run one
      wr(`OFS_T0_LOW, 8'hFE);
      wr(`OFS_T0_HIGH, 8'hFE);
      wr(`OFS_T1_LOW, 8'h55);
      wr(`OFS_CLOCK_CTRL, 8'h00);
      wr(`OFS_TIMER_MODE, 8'h37);
      wr(`OFS_TIMER_CTRL, 8'h10);
      repeat (2) i_pins.fall(3);
      chk("irq0", irq0, 1'b1);
      wr(`OFS_TIMER_CTRL, 8'h20);
      rd(`OFS_T0_LOW, 8'h00, "low byte");
      wr(`OFS_TIMER_CTRL, 8'h60);
      repeat (238) @(posedge core_clk);
      chk("irq1", irq1, 1'b1);
      wr(`OFS_TIMER_CTRL, 8'hA0);
      rd(`OFS_T0_HIGH, 8'h12, "high byte");
      rd(`OFS_T1_LOW, 8'h55, "t1 hold");
      // timer one runs with no run bit while timer 0 is split and timer one is out of its own split mode
      wr(`OFS_TIMER_MODE, 8'h17);
      repeat (238) @(posedge core_clk);
      wr(`OFS_TIMER_MODE, 8'h37);
      rd(`OFS_T1_LOW, 8'h69, "t1 run");
      // capture after a rollover, then again with clear-after-capture
      wr(`OFS_T2_LOW, 8'hFE);
      wr(`OFS_T2_HIGH, 8'hFF);
      wr(`OFS_T2_CTRL, 8'h0F);
      repeat (3) i_pins.fall(1);
      i_pins.fall(0);
      rd(`OFS_CAP_LOW, 8'h01, "capture");
      rd(`OFS_T2_CTRL, 8'hCF, "cap flags");
      chk("irq2", irq2, 1'b1);
      wr(`OFS_T2_MODE, 8'h08);
      i_pins.fall(0);
      rd(`OFS_T2_LOW, 8'h00, "cleared");
      // up reload by rollover and by a trigger fall
      wr(`OFS_T2_MODE, 8'h00);
      wr(`OFS_CAP_LOW, 8'h34);
      wr(`OFS_CAP_HIGH, 8'h12);
      wr(`OFS_T2_LOW, 8'hFF);
      wr(`OFS_T2_HIGH, 8'hFF);
      wr(`OFS_T2_CTRL, 8'h0E);
      i_pins.fall(1);
      rd(`OFS_T2_HIGH, 8'h12, "reload");
      rd(`OFS_T2_CTRL, 8'h8E, "ovf");
      wr(`OFS_T2_HIGH, 8'h00);
      i_pins.fall(0);
      rd(`OFS_T2_HIGH, 8'h12, "trig reload");
      rd(`OFS_T2_CTRL, 8'hCE, "trig flag");
      // up/down: down from the capture value wraps to FFFF, up past FFFF reloads
      wr(`OFS_T2_MODE, 8'h01);
      wr(`OFS_T2_CTRL, 8'h06);
      i_pins.level(0, 1'b0);
      i_pins.fall(1);
      rd(`OFS_T2_HIGH, 8'hFF, "down wrap");
      rd(`OFS_T2_CTRL, 8'hC6, "ud flags");
      wr(`OFS_T2_CTRL, 8'h46);
      #1 chk("ud irq", irq2, 1'b0);
      i_pins.level(0, 1'b1);
      i_pins.fall(1);
      rd(`OFS_T2_HIGH, 8'h12, "up reload");
      rd(`OFS_T2_CTRL, 8'h86, "toggle");
      // baud with clock-out from FFFE: reload every 4 cycles, so 20 toggles in 80
      wr(`OFS_T2_MODE, 8'h02);
      wr(`OFS_CAP_LOW, 8'hFE);
      wr(`OFS_CAP_HIGH, 8'hFF);
      wr(`OFS_T2_LOW, 8'hFE);
      wr(`OFS_T2_HIGH, 8'hFF);
      wr(`OFS_T2_CTRL, 8'h1C);
      repeat (8) @(posedge core_clk);
      #1 lastOut = pinOut;
      toggles = 0;
      for (int c = 0; c < 80; c++) begin
         @(posedge core_clk);
         #1 toggles += (pinOut !== lastOut);
         lastOut = pinOut;
      end
      chk("clock-out", toggles, 16'h0014);
      chk("oe", pinOe, 1'b1);
      rd(`OFS_T2_CTRL, 8'h1C, "baud ovf");
      i_pins.fall(0);
      rd(`OFS_T2_CTRL, 8'h5C, "baud trig");
      chk("baud irq", irq2, 1'b1);
      // gate pins block counting; timer one counts pin falls while timer 0 is split
      wr(`OFS_TIMER_MODE, 8'hDB);
      i_pins.level(5, 1'b0);
      i_pins.level(4, 1'b0);
      wr(`OFS_T0_LOW, 8'h00);
      wr(`OFS_TIMER_CTRL, 8'h50);
      i_pins.fall(2);
      rd(`OFS_T1_LOW, 8'h69, "t1 gate");
      rd(`OFS_T0_LOW, 8'h00, "t0 gate");
      i_pins.level(4, 1'b1);
      i_pins.fall(2);
      rd(`OFS_T1_LOW, 8'h6A, "t1 pin");
      complete_run;
   end
endmodule

`default_nettype wire
